// [verilog/esp_pkg.sv]
// Constants and types of the encoder serial position slave
// What this block does
// - After reset the block serves position frames with no setup.
// - Service mode: clock pair receives, data pair transmits, protocol external.
// - SSI self-check flag is low when healthy, high on abnormality.
// - SSI without self-check option sends only the position bits.
// - BiSS-C error bit is high when healthy, low on abnormality.
// - BiSS-C without self-check option holds the error bit at one.
// - Position sample refreshes at 35 kHz, optionally up to 375 kHz.
// - BiSS-C data flows one way, paced only by the master clock.
// - BiSS-C frame opens with data low for one clock, the acknowledge.
// - After acknowledge send a one start bit then a zero bit.
// - Then the position word in straight binary, 17 to 20 bits.
// - Then the error bit, then a warning bit that always reads one.
// - Close with inverted 6-bit CRC x^6+x+1, MSB first.
// - Start and zero bits are left out of the CRC.
// - 25 us timeout after each BiSS-C frame before the next request.
package esp_pkg;
   localparam int          CLK_MHZ        = 100;
   localparam int          POS_W          = 20;
   localparam int          CRC_W          = 6;
   localparam logic [5:0]  CRC_POLY       = 6'h03;
   localparam int          MONOFLOP_US    = 25;
   localparam int          MONOFLOP_CYC   = MONOFLOP_US * CLK_MHZ;
   localparam int          REFRESH_KHZ    = 35;
   localparam int          REFRESH_FAST_KHZ = 375;
   localparam int          REFRESH_CYC    = (CLK_MHZ * 1000) / REFRESH_KHZ;
   localparam int          REFRESH_FAST_CYC =
      (CLK_MHZ * 1000) / REFRESH_FAST_KHZ;
   localparam logic [4:0]  RES_MIN        = 5'h11;
   localparam logic [4:0]  RES_MAX        = 5'h14;
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_POS        = 8'h04;
   localparam logic [7:0]  OFS_STAT       = 8'h08;
   localparam logic [7:0]  OFS_IRQ        = 8'h0c;
   localparam logic [7:0]  OFS_MASK       = 8'h10;
   // Control fields
   localparam int          CTRL_BISS      = 0;
   localparam int          CTRL_SCHK      = 1;
   localparam int          CTRL_FAST      = 2;
   localparam int          CTRL_SVC       = 3;
   localparam int          CTRL_ABN       = 4;
   localparam int          CTRL_RES_LO    = 8;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_1400;
   // Interrupt events
   localparam int          EV_FRAME       = 0;
   localparam int          EV_TIMEOUT     = 1;
   localparam int          EV_N           = 2;
   typedef enum logic [2:0] {
      ESP_IDLE, ESP_ACK, ESP_SHIFT, ESP_WAIT
   } esp_state_t;
endpackage : esp_pkg

// [verilog/esp_slave.sv]
// Serial position slave with SSI and BiSS-C framing and AHB-Lite registers
`timescale 1ns/10ps
module esp_slave
   import esp_pkg::*;
#(
   parameter int MONOFLOP_CYCLES = MONOFLOP_CYC
)(
   input  wire logic        ref_clk,    // System clock 100 MHz
   input  wire logic        rst,        // Synchronous reset, high
   input  wire logic        hsel,       // AHB slave select
   input  wire logic [31:0] haddr,      // AHB address
   input  wire logic [1:0]  htrans,     // AHB transfer type
   input  wire logic        hwrite,     // AHB write
   input  wire logic [2:0]  hsize,      // AHB size
   input  wire logic [31:0] hwdata,     // AHB write data
   input  wire logic        hready,     // AHB bus ready
   output logic      [31:0] hrdata,     // AHB read data
   output logic             hreadyout,  // AHB slave ready
   output logic             hresp,      // AHB response, always OKAY
   input  wire logic [19:0] sensor_pos, // Raw position from sensing core
   input  wire logic        link_clk,   // Master clock (service receive)
   output logic             link_data,  // Data line (service transmit)
   output logic             svc_mode,   // Service mode active
   output logic             irq         // Level interrupt
);
   logic [31:0] ctrl;
   logic [19:0] position_word;
   logic [EV_N-1:0] irq_stat;
   logic [EV_N-1:0] irq_mask;
   logic        clk_s1, clk_s2, clk_d;
   logic        ap_valid, ap_write;
   logic [7:0]  ap_addr;
   logic [31:0] refresh_cnt;
   logic [31:0] idle_cnt;
   logic [5:0]  bit_cnt;
   logic [31:0] shreg;
   logic [5:0]  crc;
   logic        latched_biss;
   esp_state_t  state;

   // CRC step, shared by frame build
   function automatic logic [5:0] crc_step(input logic [5:0] c,
                                           input logic b);
      logic fb;
      fb = c[5] ^ b;
      crc_step = {c[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
   endfunction : crc_step

   // Field decode of control
   wire       biss_sel  = ctrl[CTRL_BISS];
   wire       schk_fit  = ctrl[CTRL_SCHK];
   wire       fast_rate = ctrl[CTRL_FAST];
   wire       abnormal  = ctrl[CTRL_ABN];
   wire [4:0] res_raw   = ctrl[CTRL_RES_LO +: 5];
   wire [4:0] res       = (res_raw < RES_MIN) ? RES_MIN :
                          (res_raw > RES_MAX) ? RES_MAX : res_raw;
   // Link clock edges, read only from second sync stage
   wire       clk_fall  = clk_d & ~clk_s2;
   wire       clk_rise  = ~clk_d & clk_s2;
   wire       tmo_hit   = (idle_cnt >= MONOFLOP_CYCLES - 1);
   wire       ssi_flag  = abnormal;
   wire       biss_err  = schk_fit ? ~abnormal : 1'b1;
   wire       wr_take   = ap_valid & ap_write & hready;
   wire [EV_N-1:0] ev;

   // AHB address phase capture; zero wait states
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr  <= 8'h00;
      end
      else if (hready)
      begin
         ap_valid <= hsel & htrans[1];
         ap_write <= hwrite;
         ap_addr  <= haddr[7:0];
      end
   end

   // Read mux: unmapped reads as zero
   wire [31:0] rd_mux =
      (haddr[7:0] == OFS_CTRL) ? ctrl :
      (haddr[7:0] == OFS_POS)  ? {12'h000, position_word} :
      (haddr[7:0] == OFS_STAT) ? {27'h0, svc_mode, state == ESP_WAIT,
                                  state != ESP_IDLE, link_data,
                                  clk_s2} :
      (haddr[7:0] == OFS_IRQ)  ? {30'h0, irq_stat} :
      (haddr[7:0] == OFS_MASK) ? {30'h0, irq_mask} : 32'h0;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         hrdata <= 32'h0;
      else if (hready && hsel && htrans[1] && !hwrite)
         hrdata <= rd_mux;
   end

   // Control and mask registers
   // reset values select position output mode
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ctrl     <= CTRL_RESET;
         irq_mask <= '0;
      end
      else if (wr_take && ap_addr == OFS_CTRL)
         ctrl <= hwdata;
      else if (wr_take && ap_addr == OFS_MASK)
         irq_mask <= hwdata[EV_N-1:0];
   end

   // Sticky events; set wins over write-one clear
   assign ev[EV_FRAME]   = (state == ESP_SHIFT) && (bit_cnt == 6'h00) &&
                           clk_rise;
   assign ev[EV_TIMEOUT] = (state == ESP_WAIT) && tmo_hit;
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         irq_stat <= '0;
      else if (wr_take && ap_addr == OFS_IRQ)
         irq_stat <= (irq_stat & ~hwdata[EV_N-1:0]) | ev;
      else
         irq_stat <= irq_stat | ev;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         irq       <= 1'b0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         irq       <= |(irq_stat & irq_mask);
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Link clock synchroniser
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         clk_s1 <= 1'b1;
         clk_s2 <= 1'b1;
         clk_d  <= 1'b1;
      end
      else
      begin
         clk_s1 <= link_clk;
         clk_s2 <= clk_s1;
         clk_d  <= clk_s2;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         refresh_cnt   <= 32'h0;
         position_word <= 20'h0;
      end
      else if (refresh_cnt >= (fast_rate ? REFRESH_FAST_CYC - 1 :
                                           REFRESH_CYC - 1))
      begin
         refresh_cnt   <= 32'h0;
         position_word <= sensor_pos;
      end
      else
         refresh_cnt <= refresh_cnt + 32'h1;
   end

   // Frame image, MSB aligned at bit 31
   logic [31:0] frame_img;
   logic [5:0]  frame_len;
   always_comb
   begin
      logic [5:0] c;
      logic [19:0] pw;
      c  = 6'h00;
      pw = position_word << (6'd20 - {1'b0, res});
      frame_img = 32'h0;
      frame_len = 6'h00;
      if (biss_sel)
      begin
         // CRC skips start and zero bits
         for (int i = 19; i >= 0; i--)
            if (i >= 20 - int'(res))
               c = crc_step(c, pw[i]);
         c = crc_step(c, biss_err);
         c = crc_step(c, 1'b1);
         // start then zero, position, error, warning
         frame_img = {2'b10, pw, 10'h0};
         frame_img[29 - int'(res) -: 8] = {biss_err, 1'b1, ~c};
         frame_len = 6'(int'(res) + 10);
      end
      else
      begin
         frame_img = {pw, 12'h0};
         if (schk_fit)
            frame_img[31 - int'(res)] = ssi_flag;
         frame_len = 6'(int'(res) + (schk_fit ? 1 : 0));
      end
   end

   // one-way shifter paced by master clock edges
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state        <= ESP_IDLE;
         link_data    <= 1'b1;
         bit_cnt      <= 6'h00;
         shreg        <= 32'h0;
         idle_cnt     <= 32'h0;
         latched_biss <= 1'b0;
         svc_mode     <= 1'b0;
      end
      else
      begin
         svc_mode <= ctrl[CTRL_SVC];
         if (clk_fall || clk_rise)
            idle_cnt <= 32'h0;
         else if (!tmo_hit)
            idle_cnt <= idle_cnt + 32'h1;
         case (state)
            ESP_IDLE:
               // service mode leaves the line to the service path
               if (clk_fall && !ctrl[CTRL_SVC])
               begin
                  latched_biss <= biss_sel;
                  shreg        <= frame_img;
                  bit_cnt      <= frame_len;
                  state        <= biss_sel ? ESP_ACK : ESP_SHIFT;
                  if (biss_sel)
                     link_data <= 1'b0;
               end
            ESP_ACK:
               // first rise after the acknowledge sends start bit
               if (clk_rise)
               begin
                  link_data <= shreg[31];
                  shreg     <= {shreg[30:0], 1'b0};
                  bit_cnt   <= bit_cnt - 6'h01;
                  state     <= ESP_SHIFT;
               end
            ESP_SHIFT:
               if (clk_rise)
               begin
                  if (bit_cnt == 6'h00)
                  begin
                     link_data <= 1'b0;
                     state     <= ESP_WAIT;
                  end
                  else
                  begin
                     link_data <= shreg[31];
                     shreg     <= {shreg[30:0], 1'b0};
                     bit_cnt   <= bit_cnt - 6'h01;
                  end
               end
            ESP_WAIT:
               if (tmo_hit)
               begin
                  link_data <= 1'b1;
                  state     <= ESP_IDLE;
               end
            default:
               state <= ESP_IDLE;
         endcase
      end
   end

   // AST_IDLE_HIGH
   AST_IDLE_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
      (state == ESP_WAIT && tmo_hit) |=> link_data && state == ESP_IDLE)
      else $error("line not idle high after timeout");
   AST_ACK_LOW: assert property (@(posedge ref_clk) disable iff (rst)
      state == ESP_ACK |-> !link_data)
      else $error("acknowledge not low");
   AST_ACK_ONE: assert property (@(posedge ref_clk) disable iff (rst)
      (state == ESP_ACK && clk_rise) |=> state == ESP_SHIFT)
      else $error("ack longer than one clock");
   AST_NO_SVC: assert property (@(posedge ref_clk) disable iff (rst)
      (state == ESP_IDLE && svc_mode && ctrl[CTRL_SVC]) |=>
      state == ESP_IDLE)
      else $error("frame started in service mode");
   AST_BISS_ERR: assert property (@(posedge ref_clk) disable iff (rst)
      !schk_fit |-> biss_err)
      else $error("error bit not one without option");
   AST_SSI_LEN: assert property (@(posedge ref_clk) disable iff (rst)
      (!biss_sel && !schk_fit) |-> frame_len == {1'b0, res})
      else $error("ssi length wrong");
   AST_BISS_LEN: assert property (@(posedge ref_clk) disable iff (rst)
      biss_sel |-> frame_len == 6'(int'(res) + 10))
      else $error("biss length wrong");
   AST_REFRESH: assert property (@(posedge ref_clk) disable iff (rst)
      refresh_cnt <= REFRESH_CYC)
      else $error("refresh overrun");
   AST_BIT_PACE: assert property (@(posedge ref_clk) disable iff (rst)
      (state == ESP_SHIFT && !clk_rise) |=> $stable(link_data))
      else $error("data moved without clock");
   AST_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
      (!biss_sel && schk_fit) |-> frame_img[31 - int'(res)] == abnormal)
      else $error("ssi flag polarity");
   COV_BISS: cover property (@(posedge ref_clk) disable iff (rst)
      state == ESP_ACK ##[1:200] ev[EV_FRAME]);
   COV_SSI: cover property (@(posedge ref_clk) disable iff (rst)
      !latched_biss && ev[EV_FRAME]);
   COV_TMO: cover property (@(posedge ref_clk) disable iff (rst)
      ev[EV_TIMEOUT]);
endmodule : esp_slave

// [tb/esp_link_master.sv]
// Behavioural serial master that clocks frames out of the slave
`timescale 1ns/10ps
module esp_link_master (
   output logic      link_clk,  // Frame clock, idle high
   input  wire logic link_data  // Serial data from slave
);
   initial link_clk = 1'b1;

   // clock paced by master only
   // Clock stands high between frames; the bench keeps the spacing
   task automatic frame(input int n, output logic ack,
                        output logic [63:0] bits);
      bits = '0;
      link_clk = 1'b0;
      #80 ack = link_data;
      for (int i = 0; i < n; i++)
      begin
         link_clk = 1'b1;
         #40 link_clk = 1'b0;
         // Sample late in the low phase, after the slave has settled
         #36 bits = {bits[62:0], link_data};
         #4;
      end
      link_clk = 1'b1;
   endtask : frame
endmodule : esp_link_master

// [tb/test_encoder_serial_position_slave.sv]
// Self-checking bench for the serial position slave
`timescale 1ns/10ps
module test_encoder_serial_position_slave import esp_pkg::*;;
   localparam int MF = 50;
   logic        ref_clk = 1'b0;
   logic        rst, hsel, hwrite, hreadyout, hresp;
   logic        link_clk, link_data, svc_mode, irq;
   logic        ack, biss, schk, abn, fast, err;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [19:0] sensor_pos;
   logic [31:0] haddr, hwdata, hrdata, rd, rv;
   logic [31:0] lfsr = 32'h00014bf6;
   logic [63:0] bits, e, pm, body;
   int          miscompares = 0;
   int          n_compared = 0;
   int          r, n;

   // Free-running system clock
   always #5 ref_clk = ~ref_clk;

   esp_slave #(.MONOFLOP_CYCLES(MF)) dut (
      .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sensor_pos(sensor_pos),
      .link_clk(link_clk), .link_data(link_data),
      .svc_mode(svc_mode), .irq(irq));

   esp_link_master partner (.link_clk(link_clk), .link_data(link_data));

   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd

   // Inverted CRC x^6+x+1 over the n low bits, first bit sent first
   function automatic logic [5:0] crc_of(input logic [63:0] d, int n);
      logic [5:0] c;
      c = 6'h00;
      for (int i = n - 1; i >= 0; i--)
         c = {c[4:0], 1'b0} ^ ((c[5] ^ d[i]) ? 6'h03 : 6'h00);
      return ~c;
   endfunction : crc_of

   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk

   // Bounded wait for the slave to answer
   task automatic wait_rdy();
      int k;
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 100);
      if (hreadyout !== 1'b1)
      begin
         miscompares++;
         give_verdict();
      end
   endtask : wait_rdy

   // One single word transfer; read data lands in rd
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : bus

   // Hang guard
   initial
   begin
      #500000;
      miscompares++;
      give_verdict();
   end

   // Main sequence
   initial
   begin
      rst <= 1'b1;
      hsel <= 1'b0;
      haddr <= 32'h0;
      htrans <= 2'b00;
      hwrite <= 1'b0;
      hsize <= 3'b010;
      hwdata <= 32'h0;
      sensor_pos <= 20'h0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      bus(1'b0, OFS_CTRL, 32'h0);
      chk(rd, {32'h0, CTRL_RESET});
      bus(1'b0, 8'h40, 32'h0);
      chk(rd, 64'h0);
      chk({irq, hresp, link_data}, 64'h1);
      $display("reset test done");
      // Every framing, resolution and self-check mix; slow refresh last
      for (int i = 0; i < 16; i++)
      begin
         rv = rnd();
         biss = i[0];
         r = 17 + i[2:1];
         schk = i[3];
         abn = rv[20];
         fast = (i != 15);
         @(posedge ref_clk);
         sensor_pos <= rv[19:0];
         bus(1'b1, OFS_CTRL, {19'h0, 5'(r), 3'h0, abn, 1'b0, fast,
                              schk, biss});
         // wait just over one refresh period so the new sensor_pos is sampled
         repeat (fast ? 300 : 2900) @(posedge ref_clk);
         bus(1'b0, OFS_POS, 32'h0);
         chk(rd, {44'h0, rv[19:0]});
         #(1 + rnd() % 8);
         n = biss ? r + 10 : r + int'(schk);
         partner.frame(n, ack, bits);
         pm = {44'h0, rv[19:0]} & ((64'h1 << r) - 64'h1);
         err = schk ? ~abn : 1'b1;
         body = (pm << 2) | {62'h0, err, 1'b1};
         if (biss)
            e = (((64'h2 << (r + 2)) | body) << 6) | crc_of(body, r + 2);
         else
            e = schk ? {pm[62:0], abn} : pm;
         chk(bits, e);
         if (biss)
            chk(ack, 64'h0);
         repeat (8) @(posedge ref_clk);
         if (biss)
            chk(link_data, 64'h0);
         repeat (MF + 8) @(posedge ref_clk);
         chk(link_data, 64'h1);
         // Both events pending but masked, then unmask the frame event and clear both
         bus(1'b0, OFS_IRQ, 32'h0);
         chk({rd, irq}, 64'h6);
         bus(1'b1, OFS_MASK, 32'h1);
         repeat (3) @(posedge ref_clk);
         chk(irq, 64'h1);
         bus(1'b1, OFS_IRQ, 32'h1);
         repeat (3) @(posedge ref_clk);
         chk(irq, 64'h0);
         bus(1'b1, OFS_IRQ, 32'h2);
         bus(1'b0, OFS_IRQ, 32'h0);
         chk(rd, 64'h0);
         bus(1'b1, OFS_MASK, 32'h0);
         $display("frame test %0d done", i);
      end
      bus(1'b1, OFS_CTRL, 32'h0000_1408);
      repeat (3) @(posedge ref_clk);
      chk(svc_mode, 64'h1);
      $display("service test done");
      give_verdict();
   end
endmodule : test_encoder_serial_position_slave
